// [rtl/crs_pkg.sv]
// Shared constants and types for the CPU register set
`default_nettype none

package crs_pkg;

	//----------------------------------------
	// Condition flag layout
	//----------------------------------------
	localparam int          FLAG_C       = 0;
	localparam int          FLAG_Z       = 1;
	localparam int          FLAG_N       = 2;
	localparam int          FLAG_I       = 3;
	localparam int          FLAG_H       = 4;
	localparam int          FLAG_V       = 7;
	localparam logic [7:0]  FLAGS_FIXED  = 8'h60;
	localparam logic [7:0]  FLAGS_RESET  = 8'h68;

	//----------------------------------------
	// Reset values and vector addresses
	//----------------------------------------
	localparam logic [7:0]  IDX_HI_RESET     = 8'h00;
	localparam logic [15:0] STACK_RESET      = 16'h00FF;
	localparam logic [7:0]  STACK_LOW_REINIT = 8'hFF;
	localparam logic [15:0] PC_RESET         = 16'h0000;
	localparam logic [15:0] VEC_HI_ADDR      = 16'hFFFE;
	localparam logic [15:0] VEC_LO_ADDR      = 16'hFFFF;

	//----------------------------------------
	// APB observation port map
	//----------------------------------------
	localparam int          APB_AW         = 8;
	localparam logic [7:0]  REG_ACC        = 8'h00;
	localparam logic [7:0]  REG_INDEX      = 8'h04;
	localparam logic [7:0]  REG_STACK      = 8'h08;
	localparam logic [7:0]  REG_PC         = 8'h0C;
	localparam logic [7:0]  REG_FLAGS      = 8'h10;
	localparam logic [7:0]  REG_CTRL       = 8'h14;
	localparam logic [7:0]  REG_STATUS     = 8'h18;
	localparam int          CTRL_HOLD      = 0;
	localparam int          STATUS_RUN     = 0;
	localparam int          STATUS_INHIBIT = 1;

	//----------------------------------------
	// Operations and sequencer states
	//----------------------------------------
	typedef enum logic [4:0] {
		OP_NOP  = 5'h00, OP_LDA  = 5'h01, OP_STA  = 5'h02, OP_LDX  = 5'h03,
		OP_STX  = 5'h04, OP_ADD  = 5'h05, OP_ADC  = 5'h06, OP_SUB  = 5'h07,
		OP_SBC  = 5'h08, OP_AND  = 5'h09, OP_ORA  = 5'h0A, OP_EOR  = 5'h0B,
		OP_BCD  = 5'h0C, OP_CLRX = 5'h0D, OP_INCX = 5'h0E, OP_DECX = 5'h0F,
		OP_COMX = 5'h10, OP_NEGX = 5'h11, OP_LSLX = 5'h12, OP_LSRX = 5'h13,
		OP_ROLX = 5'h14, OP_RORX = 5'h15, OP_TAX  = 5'h16, OP_TXA  = 5'h17,
		OP_LDHX = 5'h18, OP_SAD  = 5'h19, OP_SLR  = 5'h1A, OP_ICL  = 5'h1B,
		OP_SEI  = 5'h1C, OP_TAP  = 5'h1D, OP_TPA  = 5'h1E, OP_BITC = 5'h1F
	} crs_op_type;

	typedef enum logic [1:0] {
		ST_VEC_HI = 2'b00,
		ST_VEC_LO = 2'b01,
		ST_RUN    = 2'b10
	} crs_state_type;

endpackage

`default_nettype wire

// [rtl/crs_alu_if.sv]
// Operand and result bundle between the register set and its 8-bit ALU
`default_nettype none

interface crs_alu_if;
	import crs_pkg::*;

	crs_op_type op;
	logic [7:0] accIn;
	logic [7:0] idxIn;
	logic [7:0] memIn;
	logic [7:0] flagsIn;
	logic [7:0] res;
	logic [7:0] flagsRes;
	logic       toAcc;
	logic       toIdx;

	modport core (output op, accIn, idxIn, memIn, flagsIn, input res, flagsRes, toAcc, toIdx);
	modport alu  (input op, accIn, idxIn, memIn, flagsIn, output res, flagsRes, toAcc, toIdx);
endinterface

`default_nettype wire

// [rtl/crs_alu.sv]
// Combinational 8-bit ALU with condition flag generation
`default_nettype none

module crs_alu (
	// Operands and results
	crs_alu_if.alu bus
);
	import crs_pkg::*;

	logic [8:0] wide;
	logic [4:0] half;
	logic       cin;
	logic       hiAdj;
	logic       loAdj;
	logic       nzUpd;
	logic [7:0] a;
	logic [7:0] x;
	logic [7:0] m;
	logic [7:0] f;

	assign a = bus.accIn;
	assign x = bus.idxIn;
	assign m = bus.memIn;

	always_comb begin
		wide      = 9'h000;
		half      = 5'h00;
		cin       = 1'b0;
		hiAdj     = 1'b0;
		loAdj     = 1'b0;
		nzUpd     = 1'b1;
		f         = bus.flagsIn;
		bus.res   = a;
		bus.toAcc = 1'b0;
		bus.toIdx = 1'b0;
		case (bus.op)
			OP_LDA, OP_STA, OP_AND, OP_ORA, OP_EOR: begin
				bus.toAcc = (bus.op != OP_STA);
				if (bus.op == OP_LDA) bus.res = m;
				else if (bus.op == OP_AND) bus.res = a & m;
				else if (bus.op == OP_ORA) bus.res = a | m;
				else if (bus.op == OP_EOR) bus.res = a ^ m;
				f[FLAG_V] = 1'b0;
			end
			OP_LDX, OP_STX: begin
				bus.toIdx = (bus.op == OP_LDX);
				bus.res   = (bus.op == OP_LDX) ? m : x;
				f[FLAG_V] = 1'b0;
			end
			OP_ADD, OP_ADC: begin
				bus.toAcc = 1'b1;
				cin       = (bus.op == OP_ADC) & bus.flagsIn[FLAG_C];
				wide      = {1'b0, a} + {1'b0, m} + {8'h00, cin};
				half      = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
				bus.res   = wide[7:0];
				f[FLAG_H] = half[4];
				f[FLAG_C] = wide[8];
				f[FLAG_V] = (a[7] == m[7]) & (wide[7] != a[7]);
			end
			OP_SUB, OP_SBC: begin
				bus.toAcc = 1'b1;
				cin       = (bus.op == OP_SBC) & bus.flagsIn[FLAG_C];
				wide      = {1'b0, a} - {1'b0, m} - {8'h00, cin};
				bus.res   = wide[7:0];
				f[FLAG_C] = wide[8];
				f[FLAG_V] = (a[7] != m[7]) & (wide[7] != a[7]);
			end
			OP_BCD: begin
				bus.toAcc = 1'b1;
				loAdj     = bus.flagsIn[FLAG_H] | (a[3:0] > 4'h9);
				hiAdj     = bus.flagsIn[FLAG_C] | (a > 8'h99);
				bus.res   = a + {(hiAdj ? 4'h6 : 4'h0), (loAdj ? 4'h6 : 4'h0)};
				f[FLAG_C] = hiAdj;
			end
			OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX: begin
				bus.toIdx = 1'b1;
				f[FLAG_V] = 1'b0;
				if (bus.op == OP_CLRX) begin
					bus.res = 8'h00;
				end else if (bus.op == OP_INCX) begin
					bus.res   = x + 8'h01;
					f[FLAG_V] = (x == 8'h7F);
				end else if (bus.op == OP_DECX) begin
					bus.res   = x - 8'h01;
					f[FLAG_V] = (x == 8'h80);
				end else if (bus.op == OP_COMX) begin
					bus.res   = ~x;
					f[FLAG_C] = 1'b1;
				end else begin
					bus.res   = 8'h00 - x;
					f[FLAG_V] = (x == 8'h80);
					f[FLAG_C] = (x != 8'h00);
				end
			end
			OP_LSLX, OP_LSRX, OP_ROLX, OP_RORX: begin
				bus.toIdx = 1'b1;
				if (bus.op == OP_LSLX) bus.res = {x[6:0], 1'b0};
				else if (bus.op == OP_LSRX) bus.res = {1'b0, x[7:1]};
				else if (bus.op == OP_ROLX) bus.res = {x[6:0], bus.flagsIn[FLAG_C]};
				else bus.res = {bus.flagsIn[FLAG_C], x[7:1]};
				f[FLAG_C] = (bus.op == OP_LSLX || bus.op == OP_ROLX) ? x[7] : x[0];
				f[FLAG_V] = bus.res[7] ^ f[FLAG_C];
			end
			default: begin
				nzUpd = 1'b0;
			end
		endcase
		if (nzUpd) begin
			f[FLAG_N] = bus.res[7];
			f[FLAG_Z] = (bus.res == 8'h00);
		end
		bus.flagsRes = f | FLAGS_FIXED;
	end

endmodule

`default_nettype wire

// [rtl/crs_regs.sv]
// CPU register set: accumulator, index pair, stack pointer, program counter and condition flags
//----------------------------------------------------------------
// What this block does
// - 8-bit accumulator, ALU operand, reset keeps it
// - Index pair: upper and lower byte, 16-bit use
// - Reset clears index upper byte, keeps lower
// - Lower index byte: full 8-bit data operations
// - Stack pointer marks next free stack slot
// - Stack adjust adds sign-extended byte
// - Reset loads stack pointer with 0x00FF
// - Stack reinit touches only low byte
// - Program counter increments on every fetch
// - Change of flow loads a target instead
// - Reset loads program counter from vector
// - Flag bits 6 and 5 always one
// - Bit 7 flags two's complement overflow
// - Bit 4 records carry from bit 3
// - Decimal adjust corrects with half-carry, carry
// - Bit 3 masks maskable interrupts when one
// - Mask set after stacking, before handler; irqTake here leaves bit 3 unchanged
// - No interrupt right after mask clear
// - Bit 2 copies result's top bit
// - Bit 1 set on all-zero result
// - Bit 0 carry or borrow, shifts, bit tests
// - Registers absent from the memory map
//----------------------------------------------------------------
`default_nettype none

module crs_regs (
	// Clock, reset and enable
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   clkEn,
	// APB observation and control port
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [crs_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Operation request from the sequencer
	input  wire logic                   opValid,
	input  wire crs_pkg::crs_op_type    opCode,
	input  wire logic [15:0]            opData,
	input  wire logic                   opBit,
	output logic                        opReady,
	// Program flow and stack movement
	input  wire logic                   fetchStrobe,
	input  wire logic                   pcLoad,
	input  wire logic                   pcRel,
	input  wire logic [15:0]            pcTarget,
	input  wire logic                   spPush,
	input  wire logic                   spPull,
	// Reset vector read
	output logic                        vecReq,
	output logic      [15:0]            vecAddr,
	input  wire logic                   vecAck,
	input  wire logic [7:0]             vecData,
	// Interrupt acceptance
	input  wire logic                   irqPending,
	input  wire logic                   boundary,
	output logic                        irqTake,
	// Register views
	output logic      [7:0]             accOut,
	output logic      [15:0]            indexOut,
	output logic      [15:0]            stackOut,
	output logic      [15:0]            pcOut,
	output logic      [7:0]             flagsOut,
	output logic                        running
);
	import crs_pkg::*;

	//----------------------------------------
	// State
	//----------------------------------------
	crs_state_type state_r;
	crs_state_type state_nxt;
	logic [7:0]    acc_r;
	logic [7:0]    idxLo_r;
	logic [7:0]    idxHi_r;
	logic [15:0]   sp_r;
	logic [15:0]   pc_r;
	logic [7:0]    flags_r;
	logic          inhibit_r;
	logic          hold_r;
	logic [31:0]   prdata_r;

	logic          opGo;
	logic          clrMask;
	logic          apbWrite;
	logic          apbSetup;
	logic          addrHit;
	logic [7:0]    flagsView;
	logic [15:0]   relTarget;
	logic [15:0]   spMoved;
	logic          nz16Zero;

	crs_alu_if     aluBus ();

	crs_alu u_alu (
		.bus (aluBus)
	);

	//----------------------------------------
	// Operation acceptance
	//----------------------------------------
	assign opReady   = (state_r == ST_RUN) & ~hold_r;
	assign opGo      = clkEn & opValid & opReady;
	assign clrMask   = opGo & (opCode == OP_ICL || opCode == OP_TAP);
	assign flagsView = flags_r | FLAGS_FIXED;
	assign running   = (state_r == ST_RUN);

	assign aluBus.op      = opCode;
	assign aluBus.accIn   = acc_r;
	assign aluBus.idxIn   = idxLo_r;
	assign aluBus.memIn   = opData[7:0];
	assign aluBus.flagsIn = flagsView;

	//----------------------------------------
	// Reset vector sequencer
	//----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_VEC_HI: begin
				if (vecAck) state_nxt = ST_VEC_LO;
			end
			ST_VEC_LO: begin
				if (vecAck) state_nxt = ST_RUN;
			end
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_VEC_HI;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_VEC_HI;
		end else if (clkEn) begin
			state_r <= state_nxt;
		end
	end

	assign vecReq  = (state_r != ST_RUN);
	assign vecAddr = (state_r == ST_VEC_LO) ? VEC_LO_ADDR : VEC_HI_ADDR;

	//----------------------------------------
	// Accumulator
	//----------------------------------------
	// No reset: contents survive a system reset
	always_ff @(posedge clk) begin
		if (opGo) begin
			if (aluBus.toAcc) begin
				acc_r <= aluBus.res;
			end else if (opCode == OP_TXA) begin
				acc_r <= idxLo_r;
			end else if (opCode == OP_TPA) begin
				acc_r <= flagsView;
			end
		end
	end

	//----------------------------------------
	// Index pair
	//----------------------------------------
	// Lower byte has no reset either
	always_ff @(posedge clk) begin
		if (opGo) begin
			if (aluBus.toIdx) begin
				idxLo_r <= aluBus.res;
			end else if (opCode == OP_TAX) begin
				idxLo_r <= acc_r;
			end else if (opCode == OP_LDHX) begin
				idxLo_r <= opData[7:0];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			idxHi_r <= IDX_HI_RESET;
		end else if (opGo && opCode == OP_LDHX) begin
			idxHi_r <= opData[15:8];
		end
	end

	assign nz16Zero = (opData == 16'h0000);

	//----------------------------------------
	// Stack pointer
	//----------------------------------------
	always_comb begin
		spMoved = sp_r;
		if (spPush && !spPull) begin
			spMoved = sp_r - 16'h0001;
		end else if (spPull && !spPush) begin
			spMoved = sp_r + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sp_r <= STACK_RESET;
		end else if (clkEn && state_r == ST_RUN) begin
			if (opGo && opCode == OP_SAD) begin
				sp_r <= sp_r + {{8{opData[7]}}, opData[7:0]};
			end else if (opGo && opCode == OP_SLR) begin
				sp_r[7:0] <= STACK_LOW_REINIT;
			end else begin
				sp_r <= spMoved;
			end
		end
	end

	//----------------------------------------
	// Program counter
	//----------------------------------------
	assign relTarget = pc_r + {{8{pcTarget[7]}}, pcTarget[7:0]};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_r <= PC_RESET;
		end else if (clkEn) begin
			case (state_r)
				ST_VEC_HI: begin
					if (vecAck) pc_r[15:8] <= vecData;
				end
				ST_VEC_LO: begin
					if (vecAck) pc_r[7:0] <= vecData;
				end
				ST_RUN: begin
					if (pcLoad) begin
						pc_r <= pcTarget;
					end else if (pcRel) begin
						pc_r <= relTarget;
					end else if (fetchStrobe) begin
						pc_r <= pc_r + 16'h0001;
					end
				end
				default: begin
					pc_r <= pc_r;
				end
			endcase
		end
	end

	//----------------------------------------
	// Condition flags
	//----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_r <= FLAGS_RESET;
		end else if (opGo) begin
			case (opCode)
				OP_LDHX: begin
					flags_r[FLAG_V] <= 1'b0;
					flags_r[FLAG_N] <= opData[15];
					flags_r[FLAG_Z] <= nz16Zero;
				end
				OP_ICL: begin
					flags_r[FLAG_I] <= 1'b0;
				end
				OP_SEI: begin
					flags_r[FLAG_I] <= 1'b1;
				end
				OP_TAP: begin
					flags_r <= acc_r | FLAGS_FIXED;
				end
				OP_BITC: begin
					flags_r[FLAG_C] <= opBit;
				end
				default: begin
					flags_r <= aluBus.flagsRes;
				end
			endcase
		end
	end

	//----------------------------------------
	// Interrupt recognition
	//----------------------------------------
	// The boundary closing a mask-clear is consumed without an interrupt
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			inhibit_r <= 1'b0;
		end else if (clkEn) begin
			if (boundary) begin
				inhibit_r <= 1'b0;
			end else if (clrMask) begin
				inhibit_r <= 1'b1;
			end
		end
	end

	assign irqTake = clkEn & running & boundary & irqPending
		& ~flags_r[FLAG_I] & ~inhibit_r & ~clrMask;

	//----------------------------------------
	// APB port
	//----------------------------------------
	// Separate debug port; the CPU's own memory map never sees these
	assign apbSetup = psel & ~penable;
	assign apbWrite = clkEn & psel & penable & pwrite;
	assign addrHit  = (paddr == REG_ACC) || (paddr == REG_INDEX) || (paddr == REG_STACK)
		|| (paddr == REG_PC) || (paddr == REG_FLAGS) || (paddr == REG_CTRL)
		|| (paddr == REG_STATUS);
	assign pready   = psel & penable & clkEn;
	assign pslverr  = psel & penable & clkEn & ~addrHit;
	assign prdata   = prdata_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_r <= 1'b0;
		end else if (apbWrite && paddr == REG_CTRL) begin
			hold_r <= pwdata[CTRL_HOLD];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (clkEn && apbSetup) begin
			case (paddr)
				REG_ACC:    prdata_r <= {24'h00_0000, acc_r};
				REG_INDEX:  prdata_r <= {16'h0000, idxHi_r, idxLo_r};
				REG_STACK:  prdata_r <= {16'h0000, sp_r};
				REG_PC:     prdata_r <= {16'h0000, pc_r};
				REG_FLAGS:  prdata_r <= {24'h00_0000, flagsView};
				REG_CTRL:   prdata_r <= {31'h0000_0000, hold_r};
				REG_STATUS: prdata_r <= {30'h0000_0000, inhibit_r, running};
				default:    prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	//----------------------------------------
	// Register views
	//----------------------------------------
	assign accOut   = acc_r;
	assign indexOut = {idxHi_r, idxLo_r};
	assign stackOut = sp_r;
	assign pcOut    = pc_r;
	assign flagsOut = flagsView;

endmodule

`default_nettype wire

// [tb/crs_regs_chk.sv]
// Port-level assertions for the CPU register set
`default_nettype none

module crs_regs_chk (
	// Clock and reset
	input wire logic                clk,
	input wire logic                sys_rst,
	input wire logic                clkEn,
	// Operations and flow
	input wire logic                opValid,
	input wire logic                opReady,
	input wire crs_pkg::crs_op_type opCode,
	input wire logic [15:0]         opData,
	input wire logic                fetchStrobe,
	input wire logic                pcLoad,
	input wire logic                pcRel,
	input wire logic [15:0]         pcTarget,
	// Vector and interrupt
	input wire logic                vecReq,
	input wire logic [15:0]         vecAddr,
	input wire logic                vecAck,
	input wire logic [7:0]          vecData,
	input wire logic                irqPending,
	input wire logic                boundary,
	input wire logic                irqTake,
	// Register views
	input wire logic [15:0]         indexOut,
	input wire logic [15:0]         stackOut,
	input wire logic [15:0]         pcOut,
	input wire logic [7:0]          flagsOut,
	input wire logic                running
);
	timeunit 1ns;
	timeprecision 1ns;
	import crs_pkg::*;

	wire logic        take   = opValid && opReady && clkEn;
	wire logic        clr    = take && (opCode == OP_ICL || opCode == OP_TAP);
	wire logic [15:0] spAdj  = stackOut + {{8{opData[7]}}, opData[7:0]};
	wire logic [15:0] rspVal = {stackOut[15:8], STACK_LOW_REINIT};
	logic             blk_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Boundary in the same cycle as the clearing op is the blocked one
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			blk_r <= 1'b0;
		end else if (boundary && clkEn) begin
			blk_r <= 1'b0;
		end else if (clr) begin
			blk_r <= 1'b1;
		end
	end

	a_flags_fixed: assert property (
		flagsOut[6:5] == 2'b11) else $error("fixed flag bits not one");
	a_reset_values: assert property (
		$fell(sys_rst) |-> stackOut == STACK_RESET && indexOut[15:8] == IDX_HI_RESET)
		else $error("reset values wrong");
	a_vec_high: assert property (
		vecReq && vecAddr == VEC_HI_ADDR && vecAck && clkEn |=> vecReq && vecAddr == VEC_LO_ADDR
		&& pcOut[15:8] == $past(vecData)) else $error("vector high byte wrong");
	a_vec_done: assert property (
		vecReq && vecAddr == VEC_LO_ADDR && vecAck && clkEn |=> running && !vecReq
		&& pcOut[7:0] == $past(vecData)) else $error("vector low byte wrong");
	a_pc_fetch: assert property (
		running && clkEn && fetchStrobe && !pcLoad && !pcRel |=> pcOut == $past(pcOut) + 16'h0001)
		else $error("fetch did not step counter");
	a_pc_load: assert property (
		running && clkEn && pcLoad |=> pcOut == $past(pcTarget)) else $error("jump target not loaded");
	a_irq_mask: assert property (
		irqTake |-> boundary && irqPending && !flagsOut[FLAG_I] && running) else $error("masked irq taken");
	a_irq_inhibit: assert property (
		irqTake |-> !blk_r && !clr) else $error("irq taken after mask clear");
	a_stack_adjust: assert property (
		take && opCode == OP_SAD |=> stackOut == $past(spAdj)) else $error("stack adjust wrong");
	a_stack_reinit: assert property (
		take && opCode == OP_SLR |=> stackOut == $past(rspVal)) else $error("stack reinit wrong");
	a_mask_set: assert property (
		take && opCode == OP_SEI |=> flagsOut[FLAG_I]) else $error("mask not set");
endmodule

bind crs_regs crs_regs_chk chk_u (.clk, .sys_rst, .clkEn, .opValid, .opReady, .opCode, .opData,
	.fetchStrobe, .pcLoad, .pcRel, .pcTarget, .vecReq, .vecAddr, .vecAck, .vecData, .irqPending,
	.boundary, .irqTake, .indexOut, .stackOut, .pcOut, .flagsOut, .running);

`default_nettype wire

// [tb/crs_vec_mem.sv]
// Reset vector memory answering the vector fetch after a set lag
`default_nettype none

module crs_vec_mem #(
	parameter logic [15:0] VEC_VALUE = 16'hC35A
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Vector fetch
	input  wire logic        vecReq,
	input  wire logic [15:0] vecAddr,
	input  wire logic [3:0]  lag,
	output logic             vecAck,
	output logic      [7:0]  vecData
);
	timeunit 1ns;
	timeprecision 1ns;
	import crs_pkg::*;

	logic [3:0] waitCnt_r;
	logic [7:0] junk_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vecAck    <= 1'b0;
			waitCnt_r <= 4'h0;
			junk_r    <= 8'hA5;
		end else begin
			junk_r    <= ~junk_r;
			vecAck    <= vecReq && !vecAck && waitCnt_r >= lag;
			waitCnt_r <= (vecAck || !vecReq) ? 4'h0 : waitCnt_r + 4'h1;
		end
	end

	// No valid byte outside an acknowledge
	assign vecData = !vecAck ? junk_r : (vecAddr == VEC_HI_ADDR ? VEC_VALUE[15:8] : VEC_VALUE[7:0]);
endmodule

`default_nettype wire

// [tb/crs_regs_tb_top.sv]
// Self-checking bench for the CPU register set
`default_nettype none

module crs_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import crs_pkg::*;

	localparam logic [15:0] VEC = 16'hC35A;
	logic        clk, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr, errSeen;
	logic [7:0]  paddr, accOut, flagsOut, vecData, ea, ex, ef, b, m;
	logic [31:0] pwdata, prdata, r;
	logic        opValid, opReady, opBit, fetchStrobe, pcLoad, pcRel, spPush, spPull;
	logic        vecReq, vecAck, irqPending, boundary, irqTake, running;
	logic [15:0] opData, pcTarget, vecAddr, indexOut, stackOut, pcOut, t, af, es;
	logic [8:0]  q;
	logic [3:0]  lag;
	crs_op_type  opCode, c;
	int          failures, total_checks;

	crs_regs dut_u (.clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .opValid, .opCode, .opData, .opBit, .opReady, .fetchStrobe, .pcLoad,
		.pcRel, .pcTarget, .spPush, .spPull, .vecReq, .vecAddr, .vecAck, .vecData, .irqPending,
		.boundary, .irqTake, .accOut, .indexOut, .stackOut, .pcOut, .flagsOut, .running);
	crs_vec_mem #(.VEC_VALUE(VEC)) vec_u (.clk, .sys_rst, .vecReq, .vecAddr, .lag, .vecAck, .vecData);

	initial clk = 1'b0;
	always #20 clk = ~clk;

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic wait_hi(ref logic sig);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sig !== 1'b1 && n < 100);
		if (sig !== 1'b1) begin
			failures++;
			close_out();
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		wait_hi(pready);
		r       = prdata;
		errSeen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic op(input crs_op_type code, input logic [15:0] d);
		@(posedge clk);
		opValid <= 1'b1;
		opCode  <= code;
		opData  <= d;
		wait_hi(opReady);
		opValid <= 1'b0;
		@(negedge clk);
	endtask

	// Flow strobes: {load, relative, fetch, push, pull}
	task automatic ctl(input logic [4:0] s, input logic [15:0] tgt);
		@(posedge clk);
		{pcLoad, pcRel, fetchStrobe, spPush, spPull} <= s;
		pcTarget <= tgt;
		@(posedge clk);
		{pcLoad, pcRel, fetchStrobe, spPush, spPull} <= 5'h00;
		@(negedge clk);
	endtask

	task automatic edge_irq(input logic exp);
		@(posedge clk);
		boundary <= 1'b1;
		@(negedge clk);
		chk(irqTake, exp);
		@(posedge clk);
		boundary <= 1'b0;
	endtask

	function automatic logic [15:0] arith(input logic [7:0] a, input logic [7:0] d, input logic sub,
		input logic cin, input logic [7:0] f);
		logic [8:0] s;
		logic [4:0] hc;
		s  = sub ? {1'b0, a} - {1'b0, d} - 9'(cin) : {1'b0, a} + {1'b0, d} + 9'(cin);
		hc = {1'b0, a[3:0]} + {1'b0, d[3:0]} + 5'(cin);
		f[FLAG_C] = s[8];
		f[FLAG_V] = sub ? (a[7] ^ d[7]) & (a[7] ^ s[7]) : ~(a[7] ^ d[7]) & (a[7] ^ s[7]);
		f[FLAG_H] = sub ? f[FLAG_H] : hc[4];
		f[FLAG_N] = s[7];
		f[FLAG_Z] = s[7:0] == 8'h00;
		return {f, s[7:0]};
	endfunction

	function automatic logic [8:0] xop(input crs_op_type code, input logic [7:0] x, input logic cin);
		case (code)
			OP_CLRX: return {cin, 8'h00};
			OP_INCX: return {cin, x + 8'h01};
			OP_DECX: return {cin, x - 8'h01};
			OP_COMX: return {1'b1, ~x};
			OP_NEGX: return {x != 8'h00, 8'h00 - x};
			OP_LSLX: return {x[7], x[6:0], 1'b0};
			OP_LSRX: return {x[0], 1'b0, x[7:1]};
			OP_ROLX: return {x[7], x[6:0], cin};
			default: return {x[0], cin, x[7:1]};
		endcase
	endfunction

	initial begin
		{psel, penable, pwrite, opValid, opBit, fetchStrobe, pcLoad, pcRel} = 8'h00;
		{spPush, spPull, irqPending, boundary} = 4'h0;
		{sys_rst, clkEn} = 2'b11;
		{paddr, pwdata, opData, pcTarget, lag} = '0;
		opCode = OP_NOP;
		failures = 0;
		total_checks = 0;
		ef = FLAGS_RESET;
		void'($urandom(76603));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		wait_hi(running);
		@(negedge clk);
		chk(pcOut, VEC);
		apb(1'b0, REG_STACK, 32'h0);
		chk(r, 32'h00FF);
		apb(1'b0, REG_FLAGS, 32'h0);
		chk(r, 32'h68);
		apb(1'b0, REG_INDEX, 32'h0);
		chk(r[15:8], 8'h00);
		apb(1'b0, 8'h1C, 32'h0);
		chk({errSeen, r[30:0]}, 32'h80000000);
		apb(1'b1, REG_CTRL, 32'h1);
		@(negedge clk);
		chk(opReady, 1'b0);
		apb(1'b1, REG_CTRL, 32'h0);
		for (int i = 0; i < 24; i++) begin
			ea = (i == 0) ? 8'h7F : (i == 1) ? 8'hFF : 8'($urandom);
			b  = (i < 2) ? 8'h01 : 8'($urandom);
			c  = (i < 2) ? OP_ADD : crs_op_type'(OP_ADD + $urandom_range(3));
			op(OP_LDA, {8'h00, ea});
			ef = {1'b0, ef[6:3], ea[7], ea == 8'h00, ef[0]};
			chk(flagsOut, ef);
			op(c, {8'h00, b});
			af = arith(ea, b, c >= OP_SUB, (c == OP_ADC || c == OP_SBC) && ef[FLAG_C], ef);
			{ef, ea} = af;
			m  = (c >= OP_SUB) ? 8'hEF : 8'hFF;
			chk(accOut, ea);
			chk(flagsOut & m, ef & m);
		end
		for (int i = 0; i < 2; i++) begin
			op(OP_LDA, i ? 16'h0099 : 16'h0019);
			op(OP_ADD, i ? 16'h0001 : 16'h0028);
			op(OP_BCD, 16'h0000);
			chk({flagsOut[FLAG_C], accOut}, i ? 9'h100 : 9'h047);
		end
		ea = 8'h00;
		ef[FLAG_C] = 1'b1;
		for (int i = 0; i < 11; i++) begin
			c = crs_op_type'(OP_CLRX + i);
			t = 16'($urandom);
			op(OP_LDHX, t);
			chk(indexOut, t);
			q = (c == OP_TAX) ? {ef[0], ea} : xop(c, t[7:0], ef[0]);
			op(c, 16'h0000);
			if (c == OP_TXA) begin
				chk(accOut, t[7:0]);
				ea = t[7:0];
				q  = {ef[0], t[7:0]};
			end else begin
				chk(indexOut, {t[15:8], q[7:0]});
			end
			if (c < OP_TAX) chk(flagsOut & 8'h07, {q[7], q[7:0] == 8'h00, q[8]});
			ef[0] = q[8];
			ex = q[7:0];
		end
		es = STACK_RESET;
		ctl(5'b00010, 16'h0);
		chk(stackOut, es - 16'h0001);
		ctl(5'b00001, 16'h0);
		chk(stackOut, es);
		for (int i = 0; i < 6; i++) begin
			t = (i == 0) ? 16'h017F : (i == 1) ? 16'h0080 : 16'($urandom);
			op(i == 3 ? OP_SLR : OP_SAD, t);
			es = (i == 3) ? {es[15:8], 8'hFF} : es + {{8{t[7]}}, t[7:0]};
			chk(stackOut, es);
		end
		@(posedge clk);
		clkEn <= 1'b0;
		ctl(5'b00100, 16'h0);
		chk(pcOut, VEC);
		@(posedge clk);
		clkEn <= 1'b1;
		ctl(5'b00100, 16'h0);
		chk(pcOut, VEC + 16'h0001);
		t = 16'($urandom);
		ctl(5'b10100, t);
		chk(pcOut, t);
		ctl(5'b01000, 16'h00F0);
		chk(pcOut, t - 16'h0010);
		@(posedge clk);
		irqPending <= 1'b1;
		edge_irq(1'b0);
		op(OP_ICL, 16'h0);
		edge_irq(1'b0);
		edge_irq(1'b1);
		op(OP_SEI, 16'h0);
		chk(flagsOut[FLAG_I], 1'b1);
		edge_irq(1'b0);
		op(OP_LDA, 16'h0);
		ea = 8'h00;
		op(OP_TAP, 16'h0);
		chk(flagsOut, FLAGS_FIXED);
		edge_irq(1'b0);
		edge_irq(1'b1);
		@(posedge clk);
		sys_rst <= 1'b1;
		lag     <= 4'h3;
		repeat (3) @(posedge clk);
		chk(stackOut, STACK_RESET);
		chk(indexOut, {IDX_HI_RESET, ex});
		chk(accOut, ea);
		sys_rst <= 1'b0;
		wait_hi(running);
		@(negedge clk);
		chk(pcOut, VEC);
		close_out();
	end
endmodule

`default_nettype wire
